// ==== design/tscr_top.sv ====
// Purpose: trap status and interrupt nesting control register block
// Assumes: trap events are one-cycle pulses on the sys_clk domain
// Notes: registers reached over avalon-mm with waitrequest
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`default_nettype none

module tscr_top
    import tscr_pkg::*;
(
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic nrst, // async reset, active low
    input wire logic [ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [BE_W-1:0] avs_byteenable, // write lanes
    input wire logic [DATA_W-1:0] avs_writedata, // write data
    output logic [DATA_W-1:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall request
    input wire logic ev_ovf_a, // accumulator a overflow
    input wire logic ev_ovf_b, // accumulator b overflow
    input wire logic ev_cat_a, // accumulator a catastrophic
    input wire logic ev_cat_b, // accumulator b catastrophic
    input wire logic ev_bad_shift, // invalid accumulator shift
    input wire logic ev_div_zero, // divide by zero
    input wire logic ev_dma_err, // dma controller error
    input wire logic ev_addr_err, // address error
    input wire logic ev_stack_err, // stack error
    input wire logic ev_osc_fail, // oscillator failure
    output logic trap_math, // math error trap pulse
    output logic trap_dma, // dma error trap pulse
    output logic trap_addr, // address error trap pulse
    output logic trap_stack, // stack error trap pulse
    output logic trap_osc, // oscillator trap pulse
    output logic nesting_disable, // nested interrupts barred
    output logic [PRIO_W-1:0] cpu_priority_level, // cpu level
    output logic irq // level interrupt
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [REG_W-1:0] ctrl_reg;
    logic [REG_W-1:0] ctrl_next;
    logic [REG_W-1:0] flags_q;
    logic [STS_W-1:0] status_q;
    logic [STS_W-1:0] mask_reg;
    logic [STS_W-1:0] mask_next;
    logic [PRIO_W-1:0] prio_reg;
    logic [PRIO_W-1:0] prio_next;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] readdata_next;
    logic irq_reg;
    logic irq_next;
    logic [4:0] trap_reg;
    logic [4:0] trap_next;
    logic req;
    logic accept;
    logic fire;
    logic wr_fire;
    logic rd_fire;
    logic wr_intcon;
    logic wr_prio;
    logic wr_mask;
    logic rd_status;
    logic [REG_W-1:0] wmask;
    logic [REG_W-1:0] wdata;
    logic [REG_W-1:0] intcon_rd;
    logic trap_ovf_a;
    logic trap_ovf_b;
    logic trap_cat_a;
    logic trap_cat_b;
    logic trap_math_ev;
    logic [REG_W-1:0] flag_set;
    logic [REG_W-1:0] flag_sw_set;
    logic [REG_W-1:0] flag_clr;
    logic [STS_W-1:0] sts_clr;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    assign req = avs_read || avs_write;

    tscr_avs_hs u_hs (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .req(req),
        .waitrequest_reg(avs_waitrequest),
        .accept(accept),
        .fire(fire)
    );

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign wr_fire = fire && avs_write;
    assign rd_fire = fire && avs_read;
    assign wr_intcon = wr_fire && (avs_address == OFS_INTCON);
    assign wr_prio = wr_fire && (avs_address == OFS_PRIO);
    assign wr_mask = wr_fire && (avs_address == OFS_MASK);
    assign rd_status = rd_fire && (avs_address == OFS_STATUS);
    assign wmask = lane_mask(avs_byteenable);
    assign wdata = avs_writedata[REG_W-1:0];

    // ------------------------------------------------------------
    // trap qualification
    // ------------------------------------------------------------
    // overflow traps gated by their enables
    assign trap_ovf_a = ev_ovf_a && ctrl_reg[B_EN_A];
    assign trap_ovf_b = ev_ovf_b && ctrl_reg[B_EN_B];
    assign trap_cat_a = ev_cat_a && ctrl_reg[B_EN_CAT];
    assign trap_cat_b = ev_cat_b && ctrl_reg[B_EN_CAT];
    // shift, divide and enabled overflow causes are math error traps
    assign trap_math_ev = trap_ovf_a || trap_ovf_b || trap_cat_a
        || trap_cat_b || ev_bad_shift || ev_div_zero;

    // flag set vector from trap causes
    always_comb begin
        flag_set = REG_RST;
        flag_set[B_OVF_A] = trap_ovf_a;
        flag_set[B_OVF_B] = trap_ovf_b;
        flag_set[B_CAT_A] = trap_cat_a;
        flag_set[B_CAT_B] = trap_cat_b;
        flag_set[B_SHIFT] = ev_bad_shift;
        flag_set[B_DIV0] = ev_div_zero;
        flag_set[B_DMA] = ev_dma_err;
        flag_set[B_MATH] = trap_math_ev;
        flag_set[B_ADDR] = ev_addr_err;
        flag_set[B_STACK] = ev_stack_err;
        flag_set[B_OSC] = ev_osc_fail;
    end

    // ------------------------------------------------------------
    // trap flags
    // ------------------------------------------------------------
    // software writes of zero clear, ones set, bit 0 never stored
    assign flag_clr = wr_intcon ? (wmask & ~wdata & FLAG_MASK)
        : REG_RST;
    assign flag_sw_set = wr_intcon ? (wmask & wdata & FLAG_MASK)
        : REG_RST;

    tscr_sticky #(.W(REG_W)) u_flags (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .set_hw(flag_set),
        .set_sw(flag_sw_set),
        .clr(flag_clr),
        .flags_reg(flags_q)
    );

    // ------------------------------------------------------------
    // control bits and priority level
    // ------------------------------------------------------------
    assign ctrl_next = wr_intcon
        ? ((ctrl_reg & ~(wmask & CTRL_MASK)) | (wdata & wmask & CTRL_MASK))
        : ctrl_reg;
    // level writable only while nesting is allowed
    assign prio_next = (wr_prio && avs_byteenable[0] && !ctrl_reg[B_NEST])
        ? avs_writedata[PRIO_W-1:0] : prio_reg;
    assign mask_next = wr_mask
        ? ((mask_reg & ~wmask) | (wdata & wmask)) : mask_reg;

    // control register storage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= REG_RST;
            prio_reg <= PRIO_RST;
            mask_reg <= REG_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            prio_reg <= prio_next;
            mask_reg <= mask_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, cleared by read
    // ------------------------------------------------------------
    // clear only the bits the read actually returned
    assign sts_clr = rd_status ? readdata_reg[STS_W-1:0] : REG_RST;

    tscr_sticky #(.W(STS_W)) u_status (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .set_hw(flag_set),
        .set_sw(REG_RST),
        .clr(sts_clr),
        .flags_reg(status_q)
    );

    assign irq_next = |(status_q & mask_reg);

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    assign intcon_rd = (ctrl_reg & CTRL_MASK) | (flags_q & FLAG_MASK);

    always_comb begin
        readdata_next = readdata_reg;
        if (accept && avs_read) begin
            unique case (avs_address)
                OFS_INTCON: readdata_next = {16'h0000, intcon_rd};
                OFS_PRIO: readdata_next = {{(DATA_W-PRIO_W){1'b0}}, prio_reg};
                OFS_STATUS: readdata_next = {16'h0000, status_q};
                OFS_MASK: readdata_next = {16'h0000, mask_reg};
                default: readdata_next = RD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // trap request pulses
    // ------------------------------------------------------------
    assign trap_next = {trap_math_ev, ev_dma_err, ev_addr_err,
        ev_stack_err, ev_osc_fail};

    // output flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            readdata_reg <= RD_ZERO;
            irq_reg <= 1'b0;
            trap_reg <= '0;
        end else begin
            readdata_reg <= readdata_next;
            irq_reg <= irq_next;
            trap_reg <= trap_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = readdata_reg;
    assign irq = irq_reg;
    assign nesting_disable = ctrl_reg[B_NEST];
    assign cpu_priority_level = prio_reg;
    assign trap_math = trap_reg[4];
    assign trap_dma = trap_reg[3];
    assign trap_addr = trap_reg[2];
    assign trap_stack = trap_reg[1];
    assign trap_osc = trap_reg[0];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_nest_write;
        wr_intcon && avs_byteenable[1]
            |=> nesting_disable == $past(avs_writedata[B_NEST]);
    endproperty
    a_nest_write: assert property (p_nest_write)
        else $error("nesting disable not written");

    property p_ovf_a_flag;
        ev_ovf_a && ctrl_reg[B_EN_A] |=> flags_q[B_OVF_A] && trap_math;
    endproperty
    a_ovf_a_flag: assert property (p_ovf_a_flag)
        else $error("overflow a flag missing");

    property p_ovf_b_flag;
        ev_ovf_b && ctrl_reg[B_EN_B] |=> flags_q[B_OVF_B] && trap_math;
    endproperty
    a_ovf_b_flag: assert property (p_ovf_b_flag)
        else $error("overflow b flag missing");

    property p_cat_flags;
        (ev_cat_a || ev_cat_b) && ctrl_reg[B_EN_CAT]
            |=> (flags_q[B_CAT_A] || flags_q[B_CAT_B]) && trap_math;
    endproperty
    a_cat_flags: assert property (p_cat_flags)
        else $error("catastrophic flag missing");

    property p_ovf_a_off;
        ev_ovf_a && !ctrl_reg[B_EN_A] && !flags_q[B_OVF_A] && !wr_intcon
            |=> !flags_q[B_OVF_A];
    endproperty
    a_ovf_a_off: assert property (p_ovf_a_off)
        else $error("disabled overflow a trapped");

    property p_shift_math;
        ev_bad_shift |=> flags_q[B_SHIFT] && flags_q[B_MATH] && trap_math;
    endproperty
    a_shift_math: assert property (p_shift_math)
        else $error("shift error flags missing");

    property p_div_math;
        ev_div_zero |=> flags_q[B_DIV0] && flags_q[B_MATH] && trap_math;
    endproperty
    a_div_math: assert property (p_div_math)
        else $error("divide by zero flags missing");

    property p_dma_flag;
        ev_dma_err |=> flags_q[B_DMA] && trap_dma;
    endproperty
    a_dma_flag: assert property (p_dma_flag)
        else $error("dma flag missing");

    property p_bit0_zero;
        rd_fire && avs_address == OFS_INTCON |-> avs_readdata[B_UNUSED] == 1'b0;
    endproperty
    a_bit0_zero: assert property (p_bit0_zero)
        else $error("bit 0 read nonzero");

    property p_low_traps;
        (ev_addr_err |=> flags_q[B_ADDR])
            and (ev_stack_err |=> flags_q[B_STACK])
            and (ev_osc_fail |=> flags_q[B_OSC]);
    endproperty
    a_low_traps: assert property (p_low_traps)
        else $error("fault flags missing");

    property p_prio_locked;
        nesting_disable && wr_prio |=> $stable(cpu_priority_level);
    endproperty
    a_prio_locked: assert property (p_prio_locked)
        else $error("priority changed while locked");

    property p_flag_holds;
        flags_q[B_OVF_A] && !wr_intcon |=> flags_q[B_OVF_A];
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag dropped without write");

    property p_irq_level;
        |(status_q & mask_reg) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt not raised");

endmodule : tscr_top

`default_nettype wire

// ==== design/tscr_pkg.sv ====
// Purpose: constants shared by the trap status control register block
// Assumes: 32-bit register bus, byte offsets, 16-bit registers
// Notes: all bit positions follow the first interrupt control register
`default_nettype none

package tscr_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int REG_W = 16;
    localparam int PRIO_W = 3;
    localparam int STS_W = 16;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_INTCON = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PRIO = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MASK = 4'hC;

    // ------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------
    localparam int B_NEST = 15;
    localparam int B_OVF_A = 14;
    localparam int B_OVF_B = 13;
    localparam int B_CAT_A = 12;
    localparam int B_CAT_B = 11;
    localparam int B_EN_A = 10;
    localparam int B_EN_B = 9;
    localparam int B_EN_CAT = 8;
    localparam int B_SHIFT = 7;
    localparam int B_DIV0 = 6;
    localparam int B_DMA = 5;
    localparam int B_MATH = 4;
    localparam int B_ADDR = 3;
    localparam int B_STACK = 2;
    localparam int B_OSC = 1;
    localparam int B_UNUSED = 0;

    // ------------------------------------------------------------
    // field masks and reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] CTRL_MASK = 16'h8700;
    localparam logic [REG_W-1:0] FLAG_MASK = 16'h78FE;
    localparam logic [REG_W-1:0] REG_RST = 16'h0000;
    localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    // byte enables to a 16-bit write mask
    function automatic logic [REG_W-1:0] lane_mask(
        input logic [BE_W-1:0] be
    );
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

endpackage : tscr_pkg

`default_nettype wire

// ==== design/tscr_sticky.sv ====
// Purpose: bank of sticky flags, set by hardware, cleared by software
// Assumes: set, clear and soft set are single-cycle qualified vectors
// Notes: a hardware set in the clearing cycle wins over the clear
`default_nettype none

module tscr_sticky
    import tscr_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic [W-1:0] set_hw, // hardware set pulses
    input wire logic [W-1:0] set_sw, // software set pulses
    input wire logic [W-1:0] clr, // clear pulses
    output logic [W-1:0] flags_reg // sticky flag state
);

    logic [W-1:0] flags_next;

    // set wins over clear
    assign flags_next = set_hw | set_sw | (flags_reg & ~clr);

    // flag storage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

endmodule : tscr_sticky

`default_nettype wire

// ==== design/tscr_avs_hs.sv ====
// Purpose: waitrequest handshake for a single-cycle register slave
// Assumes: master holds a request until it sees waitrequest low
// Notes: every access answers one edge after it is first seen
`default_nettype none

module tscr_avs_hs
    import tscr_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic req, // read or write held high
    output logic waitrequest_reg, // avalon waitrequest
    output logic accept, // first cycle of a request
    output logic fire // cycle where the access completes
);

    logic waitrequest_next;

    // decode of handshake phase
    assign accept = req && waitrequest_reg;
    assign fire = req && !waitrequest_reg;
    assign waitrequest_next = !accept;

    // waitrequest flop, high while idle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest_reg <= 1'b1;
        end else begin
            waitrequest_reg <= waitrequest_next;
        end
    end

endmodule : tscr_avs_hs

`default_nettype wire

// ==== dv/tscr_trap_src.sv ====
// Purpose: trap source model for the cpu datapath and dma side
// Assumes: every cause is a one-cycle pulse on sys_clk
// Notes: pulses launch just after a rising edge and drop one edge later
`default_nettype none

module tscr_trap_src (
    input wire logic sys_clk, // system clock
    output logic [9:0] ev // ovf a b, cat a b, shift, div0, dma, adr, stk, osc
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // cause pulses
    // ---------------------------------------------------------------

    // quiet at start so no stray trap lands in reset
    initial begin
        ev = 10'h000;
    end

    // one-cycle pulse of the chosen causes, several may coincide
    task automatic pulse(input logic [9:0] causes);
        @(posedge sys_clk);
        ev <= causes;
        @(posedge sys_clk);
        ev <= 10'h000;
    endtask : pulse
endmodule : tscr_trap_src

`default_nettype wire

// ==== dv/tscr_top_test.sv ====
// Purpose: self-checking bench for the trap status control block
// Assumes: one clock, avalon-mm master that waits on waitrequest
// Notes: table of trap cases first, then hand-written awkward cases
`default_nettype none

module tscr_top_test
    import tscr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [BE_W-1:0] avs_byteenable = 4'hF;
    logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest, irq, nesting_disable;
    logic trap_math, trap_dma, trap_addr, trap_stack, trap_osc;
    logic [PRIO_W-1:0] cpu_priority_level;
    logic [9:0] ev;
    logic [31:0] q;
    int num_errors = 0;
    int check_count = 0;

    typedef struct packed {
        logic [15:0] en;
        logic [9:0] ev;
        logic [15:0] ctl;
        logic [4:0] trp;
    } tscr_row_t;
    tscr_row_t rows [14];

    tscr_trap_src tscr_trap_src_inst (.sys_clk(sys_clk), .ev(ev));

    tscr_top tscr_top_inst (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ev_ovf_a(ev[9]), .ev_ovf_b(ev[8]), .ev_cat_a(ev[7]),
        .ev_cat_b(ev[6]), .ev_bad_shift(ev[5]), .ev_div_zero(ev[4]),
        .ev_dma_err(ev[3]), .ev_addr_err(ev[2]), .ev_stack_err(ev[1]),
        .ev_osc_fail(ev[0]), .trap_math(trap_math), .trap_dma(trap_dma),
        .trap_addr(trap_addr), .trap_stack(trap_stack),
        .trap_osc(trap_osc), .nesting_disable(nesting_disable),
        .cpu_priority_level(cpu_priority_level), .irq(irq)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] adr,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        // waitrequest and read data are taken at the completing rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        chk("waitrequest", 32'h0000_0000, {31'h0, avs_waitrequest});
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // let the completing edge settle before callers look at outputs
        @(negedge sys_clk);
    endtask : bus

    task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd, 4'hF);
    endtask : wr

    task automatic rd_chk(input string what, input logic [3:0] adr,
                          input logic [31:0] exp);
        bus(1'b0, adr, 32'h0000_0000, 4'hF);
        chk(what, exp, q);
    endtask : rd_chk

    // print counts and verdict, then stop
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // ---------------------------------------------------------------
    // clock, watchdog, main sequence
    // ---------------------------------------------------------------
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // cut a hang short, the whole run needs under 2000 cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        test_done();
    end

    initial begin
        rows[0] = '{16'h0700, 10'h200, 16'h4710, 5'h10};
        rows[1] = '{16'h0000, 10'h200, 16'h0000, 5'h00};
        rows[2] = '{16'h0700, 10'h100, 16'h2710, 5'h10};
        rows[3] = '{16'h0000, 10'h100, 16'h0000, 5'h00};
        rows[4] = '{16'h0100, 10'h080, 16'h1110, 5'h10};
        rows[5] = '{16'h0100, 10'h040, 16'h0910, 5'h10};
        rows[6] = '{16'h0000, 10'h0C0, 16'h0000, 5'h00};
        rows[7] = '{16'h0000, 10'h020, 16'h0090, 5'h10};
        rows[8] = '{16'h0000, 10'h010, 16'h0050, 5'h10};
        rows[9] = '{16'h0000, 10'h008, 16'h0020, 5'h08};
        rows[10] = '{16'h0000, 10'h004, 16'h0008, 5'h04};
        rows[11] = '{16'h0000, 10'h002, 16'h0004, 5'h02};
        rows[12] = '{16'h0000, 10'h001, 16'h0002, 5'h01};
        rows[13] = '{16'h0700, 10'h320, 16'h6790, 5'h10};
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        // table: enable, cause, then trap pulse and flag readback
        foreach (rows[i]) begin
            wr(OFS_INTCON, {16'h0000, rows[i].en});
            tscr_trap_src_inst.pulse(rows[i].ev);
            @(negedge sys_clk);
            chk("trap pulses", {27'h0, rows[i].trp}, {27'h0, trap_math,
                trap_dma, trap_addr, trap_stack, trap_osc});
            chk("irq masked", 32'h0000_0000, {31'h0, irq});
            rd_chk("control", OFS_INTCON, {16'h0000, rows[i].ctl});
            $display("row %0d done", i);
        end
        // sticky flags survive reads, clear only by writing zero
        wr(OFS_INTCON, 32'h0000_0000);
        tscr_trap_src_inst.pulse(10'h010);
        repeat (5) @(negedge sys_clk);
        rd_chk("sticky", OFS_INTCON, 32'h0000_0050);
        rd_chk("sticky again", OFS_INTCON, 32'h0000_0050);
        wr(OFS_INTCON, 32'h0000_0040);
        rd_chk("partial clear", OFS_INTCON, 32'h0000_0040);
        $display("sticky test done");
        // bit 0 and byte lanes
        wr(OFS_INTCON, 32'hFFFF_FFFF);
        rd_chk("all ones", OFS_INTCON, 32'h0000_FFFE);
        bus(1'b1, OFS_INTCON, 32'h0000_0000, 4'h1);
        rd_chk("low lane", OFS_INTCON, 32'h0000_FF00);
        $display("lane test done");
        // priority level locked while nesting is barred
        wr(OFS_INTCON, 32'h0000_0000);
        wr(OFS_PRIO, 32'h0000_0005);
        chk("nesting off", 32'h0000_0000, {31'h0, nesting_disable});
        chk("level pin", 32'h0000_0005, {29'h0, cpu_priority_level});
        wr(OFS_INTCON, 32'h0000_8000);
        chk("nesting on", 32'h0000_0001, {31'h0, nesting_disable});
        wr(OFS_PRIO, 32'h0000_0002);
        rd_chk("level locked", OFS_PRIO, 32'h0000_0005);
        wr(OFS_INTCON, 32'h0000_0000);
        wr(OFS_PRIO, 32'h0000_0002);
        rd_chk("level free", OFS_PRIO, 32'h0000_0002);
        $display("priority test done");
        // unmapped place reads zero, write lands nowhere
        wr(4'h2, 32'hFFFF_FFFF);
        rd_chk("unmapped", 4'h2, 32'h0000_0000);
        rd_chk("control kept", OFS_INTCON, 32'h0000_0000);
        rd_chk("mask kept", OFS_MASK, 32'h0000_0000);
        // interrupt: masked cause, unmasked cause, read-clear
        bus(1'b0, OFS_STATUS, 32'h0000_0000, 4'hF);
        wr(OFS_MASK, 32'h0000_0020);
        tscr_trap_src_inst.pulse(10'h004);
        repeat (2) @(negedge sys_clk);
        chk("irq masked cause", 32'h0000_0000, {31'h0, irq});
        tscr_trap_src_inst.pulse(10'h008);
        repeat (2) @(negedge sys_clk);
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        rd_chk("status", OFS_STATUS, 32'h0000_0028);
        repeat (2) @(negedge sys_clk);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        rd_chk("status empty", OFS_STATUS, 32'h0000_0000);
        $display("interrupt test done");
        // second reset in mid-run with control bits set, level write blocked by nesting bar
        wr(OFS_INTCON, 32'h0000_8700);
        wr(OFS_PRIO, 32'h0000_0003);
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(negedge sys_clk);
        chk("reset wait", 32'h0000_0001, {31'h0, avs_waitrequest});
        chk("reset nest", 32'h0000_0000, {31'h0, nesting_disable});
        chk("reset level", 32'h0000_0000, {29'h0, cpu_priority_level});
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            rd_chk("reset value", 4'(a), 32'h0000_0000);
        end
        $display("reset test done");
        test_done();
    end
endmodule : tscr_top_test

`default_nettype wire
